/* logic/seg_mmu_pkg.sv */
// constants for the segment descriptor unit: register map and field layout
// assumes a 32-bit ahb-lite register bus and one 40 MHz core clock
package seg_mmu_pkg;
  localparam int NUM_DESC = 32;
  localparam int IDX_W = 5;
  // byte offsets of the register words
  localparam logic [11:0] OFF_POINTER = 12'h000;
  localparam logic [11:0] OFF_RESULT_PTR = 12'h004;
  localparam logic [11:0] OFF_ACC_BASE = 12'h008;
  localparam logic [11:0] OFF_ACC_MASK = 12'h00c;
  localparam logic [11:0] OFF_ACC_PHYS = 12'h010;
  localparam logic [11:0] OFF_ACC_SPACE = 12'h014;
  localparam logic [11:0] OFF_LOAD_OP = 12'h018;
  localparam logic [11:0] OFF_FAULT_INFO = 12'h01c;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h020;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h024;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h028;
  localparam logic [11:0] OFF_ROLE = 12'h02c;
  localparam logic [11:0] OFF_SPACE_TABLE = 12'h040; // 16 words
  localparam logic [11:0] OFF_SEG_STATE = 12'h080; // 32 words
  // segment state bit positions
  localparam int SS_ENABLE = 0;
  localparam int SS_IRQ = 1;
  localparam int SS_WPROT = 2;
  localparam int SS_USED = 3;
  localparam int SS_MOD = 4;
  // space table entries named by the cycle function code
  localparam logic [3:0] FC_USER_DATA = 4'h1;
  localparam logic [3:0] FC_USER_PROG = 4'h2;
  localparam logic [3:0] FC_SUPER_DATA = 4'h5;
  localparam logic [3:0] FC_SUPER_PROG = 4'h6;
  // status byte of a load
  localparam logic [7:0] LOAD_OK = 8'h00;
  localparam logic [7:0] LOAD_CONFLICT = 8'hff;
  // interrupt status bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_LOAD_DONE = 1;
  localparam int IRQ_SEG_HIT = 2;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_SPACE_MASK = 8'hff;
endpackage

/* logic/seg_mmu.sv */
// segment descriptor table, load sequencer, fault capture and ahb-lite slave
// assumes the translate request comes from same-clock bus-cycle logic and
// that the chip select strap is an asynchronous pin
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module seg_mmu (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic chip_sel_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic xlate_req,
  input wire logic [15:0] xlate_laddr,
  input wire logic [3:0] xlate_fc,
  input wire logic xlate_rd,
  output logic xlate_done,
  output logic [15:0] xlate_paddr,
  output logic xlate_fault,
  output logic xlate_wprot,
  output logic is_master,
  output logic irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_ANSWER} load_state_t;

  // descriptor storage
  logic [15:0] lbase_reg [seg_mmu_pkg::NUM_DESC];
  logic [15:0] lmask_reg [seg_mmu_pkg::NUM_DESC];
  logic [15:0] pbase_reg [seg_mmu_pkg::NUM_DESC];
  logic [7:0] space_reg [seg_mmu_pkg::NUM_DESC];
  logic [7:0] smask_reg [seg_mmu_pkg::NUM_DESC];
  logic [4:0] segment_state_reg [seg_mmu_pkg::NUM_DESC];
  logic [7:0] space_table_reg [16];
  logic [4:0] entry_index_pointer_reg, result_entry_pointer_reg;
  logic [15:0] logical_segment_base_reg, logical_compare_mask_reg;
  logic [15:0] physical_segment_base_reg;
  logic [7:0] space_number_reg, space_number_mask_reg;
  logic [15:0] fault_addr_reg;
  logic [7:0] fault_space_reg;
  logic fault_rd_reg;
  logic [2:0] irq_stat_reg, irq_en_reg;
  logic [1:0] strap_sync_reg;
  logic master_reg, in_reset_reg;
  load_state_t load_state_reg;
  logic [7:0] load_status_reg;
  logic dph_reg, dph_write_reg;
  logic [11:0] dph_addr_reg;
  logic [31:0] hrdata_reg;
  logic xdone_reg, xfault_reg, xwp_reg;
  logic [15:0] xpaddr_reg;

  // segment hit: address under the mask and space under its mask
  function automatic logic seg_match(input logic [15:0] a,
      input logic [15:0] b, input logic [15:0] m, input logic [7:0] s,
      input logic [7:0] sb, input logic [7:0] sm);
    seg_match = (((a ^ b) & m) == 16'h0000) && (((s ^ sb) & sm) == 8'h00);
  endfunction

  // bus address phase capture
  logic take;
  assign take = hsel && hready && htrans[1];
  logic [11:0] a_off;
  assign a_off = dph_addr_reg;

  // translation: associative search over all entries
  logic [7:0] cyc_space;
  logic [31:0] hit_vec;
  logic [4:0] hit_idx;
  logic hit_any;
  always_comb begin
    cyc_space = space_table_reg[xlate_fc];
    hit_vec = '0;
    hit_idx = 5'h00;
    hit_any = 1'b0;
    for (int i = seg_mmu_pkg::NUM_DESC - 1; i >= 0; i--) begin
      hit_vec[i] = segment_state_reg[i][seg_mmu_pkg::SS_ENABLE] &&
        seg_match(xlate_laddr, lbase_reg[i], lmask_reg[i], cyc_space,
        space_reg[i], smask_reg[i]);
      if (hit_vec[i]) begin
        hit_idx = 5'(i); // lowest index wins
        hit_any = 1'b1;
      end
    end
  end

  // conflict search for a load: overlap where both masks care
  logic [31:0] conf_vec;
  logic [4:0] conf_idx;
  logic conf_any;
  always_comb begin
    conf_vec = '0;
    conf_idx = 5'h00;
    conf_any = 1'b0;
    for (int i = seg_mmu_pkg::NUM_DESC - 1; i >= 0; i--) begin
      conf_vec[i] = segment_state_reg[i][seg_mmu_pkg::SS_ENABLE] &&
        (5'(i) != entry_index_pointer_reg) &&
        seg_match(logical_segment_base_reg, lbase_reg[i],
        logical_compare_mask_reg & lmask_reg[i], space_number_reg,
        space_reg[i], space_number_mask_reg & smask_reg[i]);
      if (conf_vec[i]) begin
        conf_idx = 5'(i);
        conf_any = 1'b1;
      end
    end
  end

  // read mux for the data phase
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (a_off >= seg_mmu_pkg::OFF_SEG_STATE)
      rd_word = {27'h0, segment_state_reg[a_off[6:2]]};
    else if (a_off >= seg_mmu_pkg::OFF_SPACE_TABLE)
      rd_word = {24'h0, space_table_reg[a_off[5:2]]};
    else
      unique case (a_off)
        seg_mmu_pkg::OFF_POINTER: rd_word = {27'h0, entry_index_pointer_reg};
        seg_mmu_pkg::OFF_RESULT_PTR:
          rd_word = {27'h0, result_entry_pointer_reg};
        seg_mmu_pkg::OFF_ACC_BASE: rd_word = {16'h0, logical_segment_base_reg};
        seg_mmu_pkg::OFF_ACC_MASK: rd_word = {16'h0, logical_compare_mask_reg};
        seg_mmu_pkg::OFF_ACC_PHYS:
          rd_word = {16'h0, physical_segment_base_reg};
        seg_mmu_pkg::OFF_ACC_SPACE:
          rd_word = {16'h0, space_number_mask_reg, space_number_reg};
        seg_mmu_pkg::OFF_FAULT_INFO:
          rd_word = {7'h0, fault_rd_reg, fault_space_reg,
            fault_addr_reg};
        seg_mmu_pkg::OFF_IRQ_STATUS: rd_word = {29'h0, irq_stat_reg};
        seg_mmu_pkg::OFF_IRQ_ENABLE: rd_word = {29'h0, irq_en_reg};
        seg_mmu_pkg::OFF_ROLE: rd_word = {31'h0, master_reg};
        default: rd_word = 32'h0000_0000;
      endcase
  end

  // next-state logic for the load sequencer, the interrupt set bits and the segment state write strobe
  logic load_rd, wr_now;
  assign load_rd = dph_reg && !dph_write_reg &&
    a_off == seg_mmu_pkg::OFF_LOAD_OP;
  assign wr_now = dph_reg && dph_write_reg;
  load_state_t load_state_next;
  logic [7:0] load_status_next;
  logic load_commit, seg_wr;
  logic [2:0] irq_set;
  always_comb begin
    load_state_next = load_state_reg;
    load_status_next = load_status_reg;
    load_commit = 1'b0;
    irq_set = 3'b000;
    unique case (load_state_reg)
      ST_IDLE: if (load_rd) load_state_next = ST_CHECK;
      ST_CHECK: begin
        load_status_next = conf_any ? seg_mmu_pkg::LOAD_CONFLICT :
          seg_mmu_pkg::LOAD_OK;
        load_commit = !conf_any;
        irq_set[seg_mmu_pkg::IRQ_LOAD_DONE] = 1'b1;
        load_state_next = ST_ANSWER;
      end
      ST_ANSWER: load_state_next = ST_IDLE;
    endcase
    irq_set[seg_mmu_pkg::IRQ_FAULT] = xlate_req && !hit_any;
    irq_set[seg_mmu_pkg::IRQ_SEG_HIT] = xlate_req && hit_any &&
      segment_state_reg[hit_idx][seg_mmu_pkg::SS_IRQ];
    seg_wr = wr_now && a_off >= seg_mmu_pkg::OFF_SEG_STATE;
  end

  // strap sampling and master role
  always_ff @(posedge core_clk) begin
    strap_sync_reg <= {strap_sync_reg[0], !chip_sel_n};
    in_reset_reg <= srst;
    if (!srst && in_reset_reg) begin
      master_reg <= strap_sync_reg[1];
    end
  end

  // descriptor table; zero mapping only in the master
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < seg_mmu_pkg::NUM_DESC; i++) begin
      if (srst) begin
        segment_state_reg[i] <= 5'h00;
      end else if (in_reset_reg && i == 0) begin
        lbase_reg[0] <= seg_mmu_pkg::RST_WORD;
        lmask_reg[0] <= seg_mmu_pkg::RST_WORD;
        pbase_reg[0] <= seg_mmu_pkg::RST_WORD;
        space_reg[0] <= 8'h00;
        smask_reg[0] <= 8'h00;
        segment_state_reg[0] <= {4'h0, strap_sync_reg[1]};
      end else if (load_commit && 5'(i) == entry_index_pointer_reg) begin
        lbase_reg[i] <= logical_segment_base_reg;
        lmask_reg[i] <= logical_compare_mask_reg;
        pbase_reg[i] <= physical_segment_base_reg;
        space_reg[i] <= space_number_reg;
        smask_reg[i] <= space_number_mask_reg;
        segment_state_reg[i] <= 5'h01;
      end else begin
        if (seg_wr && a_off[6:2] == 5'(i)) begin
          segment_state_reg[i][seg_mmu_pkg::SS_IRQ] <= hwdata[1];
          segment_state_reg[i][seg_mmu_pkg::SS_WPROT] <= hwdata[2];
          if (!hwdata[0])
            segment_state_reg[i][seg_mmu_pkg::SS_ENABLE] <= 1'b0;
          if (!hwdata[3])
            segment_state_reg[i][seg_mmu_pkg::SS_USED] <= 1'b0;
          if (!hwdata[4])
            segment_state_reg[i][seg_mmu_pkg::SS_MOD] <= 1'b0;
        end
        // a hit in the same cycle sets the flag over the clear
        if (xlate_req && hit_vec[i]) begin
          segment_state_reg[i][seg_mmu_pkg::SS_USED] <= 1'b1;
          if (!xlate_rd)
            segment_state_reg[i][seg_mmu_pkg::SS_MOD] <= 1'b1;
        end
      end
    end
  end

  // system registers, fault capture and interrupts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      entry_index_pointer_reg <= 5'h00;
      result_entry_pointer_reg <= 5'h00;
      logical_segment_base_reg <= seg_mmu_pkg::RST_WORD;
      logical_compare_mask_reg <= seg_mmu_pkg::RST_WORD;
      physical_segment_base_reg <= seg_mmu_pkg::RST_WORD;
      space_number_reg <= 8'h00;
      space_number_mask_reg <= seg_mmu_pkg::RST_SPACE_MASK;
      fault_addr_reg <= 16'h0000;
      fault_space_reg <= 8'h00;
      fault_rd_reg <= 1'b0;
      irq_stat_reg <= 3'b000;
      irq_en_reg <= 3'b000;
      load_state_reg <= ST_IDLE;
      load_status_reg <= seg_mmu_pkg::LOAD_OK;
      for (int i = 0; i < 16; i++) space_table_reg[i] <= 8'h00;
    end else begin
      load_state_reg <= load_state_next;
      load_status_reg <= load_status_next;
      if (load_state_reg == ST_CHECK && conf_any)
        result_entry_pointer_reg <= conf_idx;
      if (xlate_req && !hit_any) begin
        fault_addr_reg <= xlate_laddr;
        fault_space_reg <= cyc_space;
        fault_rd_reg <= xlate_rd;
      end
      if (wr_now) begin
        if (a_off >= seg_mmu_pkg::OFF_SPACE_TABLE &&
            a_off < seg_mmu_pkg::OFF_SEG_STATE)
          space_table_reg[a_off[5:2]] <= hwdata[7:0];
        unique case (a_off)
          seg_mmu_pkg::OFF_POINTER: entry_index_pointer_reg <= hwdata[4:0];
          seg_mmu_pkg::OFF_ACC_BASE: logical_segment_base_reg <= hwdata[15:0];
          seg_mmu_pkg::OFF_ACC_MASK: logical_compare_mask_reg <= hwdata[15:0];
          seg_mmu_pkg::OFF_ACC_PHYS: physical_segment_base_reg <= hwdata[15:0];
          seg_mmu_pkg::OFF_ACC_SPACE: begin
            space_number_reg <= hwdata[7:0];
            space_number_mask_reg <= hwdata[15:8];
          end
          seg_mmu_pkg::OFF_IRQ_ENABLE: irq_en_reg <= hwdata[2:0];
          default: ;
        endcase
      end
      // set wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg &
        ~((wr_now && a_off == seg_mmu_pkg::OFF_IRQ_CLEAR) ? hwdata[2:0] :
        3'b000)) | irq_set;
    end
  end

  // ahb-lite slave: reads wait once, a load read until its status is known
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dph_reg <= 1'b0;
      dph_write_reg <= 1'b0;
      dph_addr_reg <= 12'h000;
      hreadyout <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      // low from the address phase, so hrdata stands before it is taken
      if (take && !hwrite)
        hreadyout <= 1'b0;
      else if ((dph_reg && !dph_write_reg && !load_rd) ||
          load_state_reg == ST_ANSWER)
        hreadyout <= 1'b1;
      if (load_state_reg == ST_CHECK)
        hrdata_reg <= {24'h0, load_status_next};
      else if (dph_reg && !load_rd)
        hrdata_reg <= rd_word;
      if (hreadyout || load_state_reg == ST_ANSWER) begin
        dph_reg <= take;
        dph_write_reg <= hwrite;
        dph_addr_reg <= haddr[11:0];
      end else begin
        dph_reg <= 1'b0;
      end
    end
  end
  always_comb hrdata = hrdata_reg;
  assign hresp = 1'b0;

  // registered translation answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xdone_reg <= 1'b0;
      xfault_reg <= 1'b0;
      xwp_reg <= 1'b0;
      xpaddr_reg <= 16'h0000;
      irq <= 1'b0;
    end else begin
      xdone_reg <= xlate_req;
      xfault_reg <= xlate_req && !hit_any;
      xwp_reg <= xlate_req && hit_any && !xlate_rd &&
        segment_state_reg[hit_idx][seg_mmu_pkg::SS_WPROT];
      xpaddr_reg <= (xlate_laddr & ~lmask_reg[hit_idx]) |
        (pbase_reg[hit_idx] & lmask_reg[hit_idx]);
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end
  assign xlate_done = xdone_reg;
  assign xlate_fault = xfault_reg;
  assign xlate_wprot = xwp_reg;
  assign xlate_paddr = xpaddr_reg;
  assign is_master = master_reg;
endmodule
`default_nettype wire

/* dv/ahb_master_model.sv */
// ahb-lite master standing for the processor and its software
// assumes one slave whose hreadyout comes back as hready
`timescale 1ns/1ps
`default_nettype none
module ahb_master_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic go_write,
  input wire logic [31:0] go_addr,
  input wire logic [31:0] go_wdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic ack,
  output logic [31:0] rdata,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  logic [1:0] st;
  // one single word transfer at a time, held until hready is seen
  always @(posedge core_clk) begin
    ack <= 1'b0;
    hsize <= 3'h2;
    if (srst) begin
      st <= 2'd0;
      htrans <= 2'h0;
      hwdata <= 32'h0;
    end else if (st == 2'd0) begin
      hwdata <= ~hwdata; // released data toggles so stale values show
      if (go && !ack) begin
        haddr <= go_addr;
        hwrite <= go_write;
        htrans <= 2'h2;
        st <= 2'd1;
      end
    end else if (hready) begin
      htrans <= 2'h0;
      hwdata <= go_wdata;
      st <= st + 2'd1;
      if (st == 2'd2) begin
        rdata <= hrdata;
        ack <= 1'b1;
        st <= 2'd0;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/seg_mmu_sva.sv */
// port-level checks of the segment descriptor unit
// assumes a single slave on the bus and one clock domain
`timescale 1ns/1ps
`default_nettype none
module seg_mmu_sva (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic xlate_req,
  input wire logic [15:0] xlate_laddr,
  input wire logic xlate_done,
  input wire logic [15:0] xlate_paddr,
  input wire logic xlate_fault,
  input wire logic xlate_wprot,
  input wire logic is_master
);
  logic [1:0] age_reg;
  logic [1:0] age_next;
  logic fresh_reg;
  logic fresh_next;
  logic pend_reg;
  logic pend_next;
  // any write may reprogram descriptor zero, so identity holds until then
  always_comb begin
    age_next = (age_reg == 2'd3) ? age_reg : age_reg + 2'd1;
    fresh_next = fresh_reg && !(hsel && hready && htrans[1] && hwrite);
    // a load read is pending until its data phase ends
    pend_next = pend_reg;
    if (hsel && hready && htrans[1] && !hwrite &&
        haddr[11:0] == seg_mmu_pkg::OFF_LOAD_OP)
      pend_next = 1'b1;
    else if (hreadyout)
      pend_next = 1'b0;
    if (srst) begin
      age_next = 2'd0;
      fresh_next = 1'b1;
      pend_next = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    age_reg <= age_next;
    fresh_reg <= fresh_next;
    pend_reg <= pend_next;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_load_rd;
    hsel && hready && htrans[1] && !hwrite &&
      haddr[11:0] == seg_mmu_pkg::OFF_LOAD_OP;
  endsequence
  sequence s_stall;
    !hreadyout ##[1:4] hreadyout;
  endsequence
  property p_done; xlate_req |=> xlate_done; endproperty
  property p_nodone; !xlate_req |=> !xlate_done; endproperty
  property p_ident;
    fresh_reg && age_reg == 2'd3 && is_master && xlate_req |=>
      xlate_paddr == $past(xlate_laddr) && !xlate_fault;
  endproperty
  property p_role; age_reg == 2'd3 |-> $stable(is_master); endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_load; s_load_rd |-> ##[1:2] s_stall; endproperty
  property p_status;
    pend_reg && hreadyout |-> hrdata[7:0] == seg_mmu_pkg::LOAD_OK ||
      hrdata[7:0] == seg_mmu_pkg::LOAD_CONFLICT;
  endproperty
  property p_excl; xlate_done |-> !(xlate_fault && xlate_wprot); endproperty
  a_done: assert property (p_done) else $error("no done");
  a_nodone: assert property (p_nodone) else $error("stray done");
  a_ident: assert property (p_ident) else $error("not identity");
  a_role: assert property (p_role) else $error("role moved");
  a_okay: assert property (p_okay) else $error("bad resp");
  a_load: assert property (p_load) else $error("load timing");
  a_status: assert property (p_status) else $error("bad status");
  a_excl: assert property (p_excl) else $error("fault and wprot");
endmodule
bind seg_mmu seg_mmu_sva chk (.core_clk(core_clk), .srst(srst),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsel(hsel),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .xlate_req(xlate_req), .xlate_laddr(xlate_laddr),
  .xlate_done(xlate_done), .xlate_paddr(xlate_paddr),
  .xlate_fault(xlate_fault), .xlate_wprot(xlate_wprot),
  .is_master(is_master));
`default_nettype wire

/* dv/tb.sv */
// self-checking bench: bus master model plus a descriptor table model
// assumes the unit is the only slave and is strapped as master
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic chip_sel_n = 1'b0;
  logic xlate_req = 1'b0;
  logic [15:0] xlate_laddr = 16'h0;
  logic [3:0] xlate_fc = 4'h0;
  logic xlate_rd = 1'b1;
  logic go = 1'b0;
  logic go_write = 1'b0;
  logic [31:0] go_addr = 32'h0;
  logic [31:0] go_wdata = 32'h0;
  logic ack, xlate_done, xlate_fault, xlate_wprot, is_master, irq;
  logic hreadyout, hresp, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rdata, got, fi;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] xlate_paddr;
  int mismatches = 0;
  int comparisons = 0;
  int lb[32], lm[32], pb[32], sn[32], sm[32], en[32], wp[32], ast[16];
  always #12.5 core_clk = ~core_clk;
  ahb_master_model PM (.core_clk(core_clk), .srst(srst), .go(go),
    .go_write(go_write), .go_addr(go_addr), .go_wdata(go_wdata),
    .hready(hreadyout), .hrdata(hrdata), .ack(ack), .rdata(rdata),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  seg_mmu DUT (.core_clk(core_clk), .srst(srst), .chip_sel_n(chip_sel_n),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hsel(1'b1), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .xlate_req(xlate_req),
    .xlate_laddr(xlate_laddr), .xlate_fc(xlate_fc), .xlate_rd(xlate_rd),
    .xlate_done(xlate_done), .xlate_paddr(xlate_paddr),
    .xlate_fault(xlate_fault), .xlate_wprot(xlate_wprot),
    .is_master(is_master), .irq(irq));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus transfer through the master model, bounded wait on ack
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge core_clk);
    go <= 1'b1;
    go_write <= w;
    go_addr <= {20'h0, a};
    go_wdata <= d;
    for (n = 0; n < 60 && ack !== 1'b1; n++) @(posedge core_clk);
    if (n == 60) begin
      mismatches++;
      wrap_up();
    end
    go <= 1'b0;
    got = rdata;
  endtask
  // lowest matching enabled entry, or -1 when nothing matches
  function automatic int hit(int la, int s);
    for (int i = 0; i < 32; i++)
      if (en[i] && ((la ^ lb[i]) & lm[i]) == 0 &&
          ((s ^ sn[i]) & sm[i]) == 0) return i;
    return -1;
  endfunction
  task automatic xl(logic [15:0] la, logic [3:0] fc, logic r);
    int i;
    i = hit(la, ast[fc]);
    @(posedge core_clk);
    xlate_req <= 1'b1;
    xlate_laddr <= la;
    xlate_fc <= fc;
    xlate_rd <= r;
    @(posedge core_clk);
    xlate_req <= 1'b0;
    xlate_laddr <= ~la;
    #1;
    chk("done", 32'h1, {31'h0, xlate_done});
    chk("fault", {31'h0, i < 0}, {31'h0, xlate_fault});
    if (i < 0) fi = {7'h0, r, 8'(ast[fc]), la};
    if (i < 0) return;
    chk("paddr", (la & ~lm[i]) | (pb[i] & lm[i]), {16'h0, xlate_paddr});
    chk("wprot", {31'h0, !r && wp[i]}, {31'h0, xlate_wprot});
  endtask
  // software loads pointer and accumulator, then reads the load location
  task automatic load(int p, int b, int m, int ph, int s);
    int c;
    c = -1;
    for (int i = 31; i >= 0; i--)
      if (en[i] && i != p && ((b ^ lb[i]) & m & lm[i]) == 0 &&
          ((s ^ sn[i]) & 127 & sm[i]) == 0) c = i;
    bus(1'b1, seg_mmu_pkg::OFF_POINTER, p);
    bus(1'b1, seg_mmu_pkg::OFF_ACC_BASE, b);
    bus(1'b1, seg_mmu_pkg::OFF_ACC_MASK, m);
    bus(1'b1, seg_mmu_pkg::OFF_ACC_PHYS, ph);
    bus(1'b1, seg_mmu_pkg::OFF_ACC_SPACE, 32'h7f00 | s);
    bus(1'b0, seg_mmu_pkg::OFF_LOAD_OP, 0);
    chk("status", (c < 0) ? 0 : 255, {24'h0, got[7:0]});
    if (c >= 0) bus(1'b0, seg_mmu_pkg::OFF_RESULT_PTR, 0);
    if (c >= 0) chk("result ptr", c, got);
    if (c >= 0) return;
    lb[p] = b;
    lm[p] = m;
    pb[p] = ph;
    sn[p] = s;
    sm[p] = 127;
    en[p] = 1;
  endtask
  task automatic seg_wr(int n, logic [31:0] v);
    bus(1'b1, seg_mmu_pkg::OFF_SEG_STATE + 12'(4 * n), v);
    en[n] = en[n] && v[0];
    wp[n] = v[2];
  endtask
  task automatic irq_chk(logic e);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  initial begin
    void'($urandom(32'h911f9e7b));
    en[0] = 1;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chip_sel_n <= 1'b1;
    chk("master", 32'h1, {31'h0, is_master});
    bus(1'b0, seg_mmu_pkg::OFF_ROLE, 0);
    chk("role", 32'h1, got);
    repeat (6) xl(16'($urandom), 4'($urandom), 1'b1);
    bus(1'b0, 12'h030, 0);
    chk("unmapped", 32'h0, got);
    $display("test reset identity done");
    load(1, 16'h4000, 16'hc000, 16'h8000, 1);
    seg_wr(0, 32'h0);
    load(1, 16'h4000, 16'hc000, 16'h8000, 1);
    load(2, 16'h0000, 16'he000, 16'h2000, 1);
    load(31, 16'h0000, 16'h0000, 16'h0000, 1);
    load(31, 16'h2000, 16'he000, 16'h6000, 2);
    for (int k = 1; k < 3; k++) begin
      bus(1'b1, seg_mmu_pkg::OFF_SPACE_TABLE + 12'(4 * k), k);
      ast[k] = k;
    end
    repeat (10) xl(16'($urandom), 4'(1 + $urandom % 2), 1'b1);
    $display("test load and translate done");
    bus(1'b1, seg_mmu_pkg::OFF_SPACE_TABLE + 12'h8, 1);
    ast[2] = 1;
    xl(16'h4123, 4'h2, 1'b1);
    bus(1'b1, seg_mmu_pkg::OFF_SPACE_TABLE + 12'h8, 5);
    ast[2] = 5;
    xl(16'h4123, 4'h2, 1'b0);
    bus(1'b0, seg_mmu_pkg::OFF_FAULT_INFO, 0);
    chk("fault info", fi, got);
    bus(1'b1, seg_mmu_pkg::OFF_IRQ_ENABLE, 32'h1);
    irq_chk(1'b1);
    bus(1'b1, seg_mmu_pkg::OFF_IRQ_ENABLE, 32'h0);
    irq_chk(1'b0);
    bus(1'b1, seg_mmu_pkg::OFF_IRQ_CLEAR, 32'h7);
    bus(1'b1, seg_mmu_pkg::OFF_IRQ_ENABLE, 32'h1);
    irq_chk(1'b0);
    bus(1'b0, seg_mmu_pkg::OFF_IRQ_STATUS, 0);
    chk("irq status", 32'h0, got);
    $display("test fault capture done");
    seg_wr(1, 32'h1f);
    bus(1'b0, seg_mmu_pkg::OFF_SEG_STATE + 12'h4, 0);
    chk("seg state", 32'h0f, got);
    xl(16'h4000, 4'h1, 1'b0);
    bus(1'b0, seg_mmu_pkg::OFF_IRQ_STATUS, 0);
    chk("seg hit irq", 32'h1, {31'h0, got[2]});
    seg_wr(1, 32'h0);
    bus(1'b0, seg_mmu_pkg::OFF_SEG_STATE + 12'h4, 0);
    chk("seg state", 32'h0, got);
    xl(16'h4000, 4'h1, 1'b1);
    $display("test segment state done");
    wrap_up();
  end
endmodule
`default_nettype wire
